// ===== include/pci_master_cfg_pkg.sv
// types for the master config and hook register bank
// assumes the _regs.svh header for all figures
package pci_master_cfg_pkg;
   // master memory request from the internal master memory interface
   typedef struct packed
   {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [7:0] burst_len;
   } mem_req_t;
   // command issued on the bus by the command generator
   typedef enum logic [3:0]
   {
      CMD_MEM_READ = 4'h6,
      CMD_MEM_WRITE = 4'h7,
      CMD_MEM_READ_MULT = 4'hc,
      CMD_MEM_READ_LINE = 4'he,
      CMD_MEM_WRITE_INV = 4'hf
   } bus_cmd_t;
   typedef struct packed
   {
      logic valid;
      bus_cmd_t cmd;
      logic [31:0] addr;
   } bus_issue_t;
   typedef struct packed
   {
      logic cfg_pending;
      logic io_pending;
      logic mem_held;
      mem_req_t mem;
   } proxy_hold_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_HOLD = 3'b010,
      ST_ISSUE = 3'b100
   } mem_state_t;
endpackage

// ===== include/pci_master_cfg_regs.svh
// register offsets, field positions, reset values of the master config
// and hook register bank; included by the design
`ifndef PCI_MASTER_CFG_REGS_SVH
`define PCI_MASTER_CFG_REGS_SVH
`define OFS_MASTER_CFG 12'h300
`define OFS_ADDR_SUB_BASE 12'h200
`define OFS_IDENTITY_PROG 12'h394
`define OFS_CLASS_REV_PROG 12'h39c
`define OFS_SUBSYS_PROG 12'h3a0
`define OFS_LAT_GNT_PROG 12'h3a4
`define OFS_CFG_COMPLETE 12'h3ac
`define OFS_STATUS 12'h304
`define BIT_CFG_FLUSH 10
`define BIT_IO_FLUSH 9
`define BIT_MEM_FLUSH 8
`define BIT_RD_MULT 2
`define BIT_RD_LINE 1
`define BIT_WR_INV 0
`define MASTER_CFG_MASK 32'h0000_0707
`define ADDR_SUB_MASK 32'hff80_0000
`define LAT_GNT_MASK 32'h0000_ffff
`define SUB_MSB 31
`define SUB_LSB 23
`define NUM_SUB 32
`define RST_MASTER_CFG 32'h0000_0000
`define RST_ADDR_SUB 32'h0000_0000
`define RST_IDENTITY 32'h0000_0000
`define RST_CLASS_REV 32'h0000_0000
`define RST_SUBSYS 32'h0000_0000
`define RST_LAT_GNT 32'h0000_0000
`define RST_CFG_COMPLETE 32'h0000_0000
`define BURST_MIN_LINE 8'h08
`endif

// ===== rtl/pci_master_cfg.sv
// register bank for master config, address substitution and hook regs,
// plus the master memory request gate that these registers steer.
// assumes an APB master on CLK and pci reset as a synchronous pulse.
// the internal master holds a request until MEM_REQ_READY is high.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "pci_master_cfg_regs.svh"
module pci_master_cfg
   import pci_master_cfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic PCI_RST,
   input wire logic BUS_MASTER_ENABLE,
   input wire logic CFG_PROXY_REQ,
   input wire logic IO_PROXY_REQ,
   input wire logic PROXY_DONE,
   output logic CFG_PROXY_PENDING,
   output logic IO_PROXY_PENDING,
   input wire mem_req_t MEM_REQ,
   output logic MEM_REQ_READY,
   output bus_issue_t BUS_ISSUE,
   input wire logic BUS_ISSUE_READY,
   output logic [31:0] IDENTITY_MIRROR,
   output logic [31:0] CLASS_REVISION_MIRROR,
   output logic [31:0] SUBSYSTEM_MIRROR,
   output logic [15:0] LATENCY_GRANT_MIRROR,
   output logic HOST_ACCESS_ALLOWED
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // program registers and mirrors are kept apart, so a program write
   // never disturbs the live header until the next pci reset
   typedef struct packed
   {
      logic [31:0] master_configuration;
      logic [`NUM_SUB-1:0][8:0] upper_addr_replace;
      logic [31:0] identity_program;
      logic [31:0] class_revision_program;
      logic [31:0] subsystem_identity_program;
      logic [15:0] latency_grant_program;
      logic configuration_complete;
      logic [31:0] identity_mirror;
      logic [31:0] class_revision_mirror;
      logic [31:0] subsystem_mirror;
      logic [15:0] latency_grant_mirror;
      proxy_hold_t hold;
      mem_state_t mstate;
      bus_issue_t issue;
      logic [31:0] prdata;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic [31:0] sub_rd [`NUM_SUB];
   logic access;
   logic wr;
   logic rd;
   logic is_sub;
   logic [4:0] sub_idx;
   logic mapped;
   logic [31:0] rdata;
   logic read_mult_en;
   logic read_line_en;
   logic write_inv_en;
   logic mem_flush_en;
   logic long_burst;
   logic [31:0] xlat_addr;
   bus_cmd_t mem_cmd;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // zero wait states: every access completes in its first access cycle;
   // read data is loaded at the setup edge, so it already stands in the
   // access phase where the master samples it together with pready
   assign access = PSEL & PENABLE;
   assign wr = access & PWRITE;
   assign rd = PSEL & ~PENABLE & ~PWRITE;
   assign is_sub = (PADDR[11:7] == 5'(`OFS_ADDR_SUB_BASE >> 7));
   assign sub_idx = PADDR[6:2];
   assign PREADY = 1'b1;
   // unmapped or misaligned: error response, write dropped, read zero
   assign PSLVERR = access & ~mapped;
   assign PRDATA = cur.prdata;

   // substitution registers read back with reserved bits as zero
   // (the reserved low bits are not stored, so they cannot read back)
   generate
      for (genvar i = 0; i < `NUM_SUB; i++)
      begin : g_sub
         assign sub_rd[i] = {cur.upper_addr_replace[i], 23'h000000};
      end
   endgenerate

   // read mux, also flags unmapped or misaligned addresses;
   // misaligned offsets are refused, not rounded down, so software
   // never reaches a neighbouring register by accident
   always_comb
   begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      if (PADDR[1:0] != 2'h0)
         mapped = 1'b0;
      else if (is_sub)
         rdata = sub_rd[sub_idx];
      else
         case (PADDR)
            `OFS_MASTER_CFG: rdata = cur.master_configuration;
            `OFS_IDENTITY_PROG: rdata = cur.identity_program;
            `OFS_CLASS_REV_PROG: rdata = cur.class_revision_program;
            `OFS_SUBSYS_PROG: rdata = cur.subsystem_identity_program;
            `OFS_LAT_GNT_PROG: rdata = {16'h0000, cur.latency_grant_program};
            `OFS_CFG_COMPLETE: rdata = {31'h0, cur.configuration_complete};
            `OFS_STATUS: rdata = {27'h0, cur.hold.mem_held,
               cur.hold.io_pending, cur.hold.cfg_pending, 2'h0};
            default: mapped = 1'b0;
         endcase
   end

   // ------------------------------------------------------------
   // master memory path
   // ------------------------------------------------------------
   // enables come from the live register: a change applies to the next
   // request that leaves the hold state, never to one already issued
   assign read_mult_en = cur.master_configuration[`BIT_RD_MULT];
   assign read_line_en = cur.master_configuration[`BIT_RD_LINE];
   assign write_inv_en = cur.master_configuration[`BIT_WR_INV];
   assign mem_flush_en = cur.master_configuration[`BIT_MEM_FLUSH];
   assign long_burst = cur.hold.mem.burst_len >= `BURST_MIN_LINE;
   // window slot picked by address bits 27-23 of the 256 MB window
   assign xlat_addr = {cur.upper_addr_replace[cur.hold.mem.addr[27:23]],
      cur.hold.mem.addr[22:0]};

   // command choice; the enhanced commands only when software allows
   // short bursts always fall back to the plain read or write command
   always_comb
   begin
      if (cur.hold.mem.write)
         mem_cmd = (long_burst && write_inv_en) ? CMD_MEM_WRITE_INV
            : CMD_MEM_WRITE;
      else if (long_burst && read_mult_en)
         mem_cmd = CMD_MEM_READ_MULT;
      else if (long_burst && read_line_en)
         mem_cmd = CMD_MEM_READ_LINE;
      else
         mem_cmd = CMD_MEM_READ;
   end

   // the gate takes a request only when idle; flushing also drains
   // issue is a register, so it stands unchanged until the agent takes it
   assign MEM_REQ_READY = (cur.mstate == ST_IDLE);
   assign BUS_ISSUE = cur.issue;
   assign CFG_PROXY_PENDING = cur.hold.cfg_pending;
   assign IO_PROXY_PENDING = cur.hold.io_pending;
   assign IDENTITY_MIRROR = cur.identity_mirror;
   assign CLASS_REVISION_MIRROR = cur.class_revision_mirror;
   assign SUBSYSTEM_MIRROR = cur.subsystem_mirror;
   assign LATENCY_GRANT_MIRROR = cur.latency_grant_mirror;
   assign HOST_ACCESS_ALLOWED = cur.configuration_complete;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_cur = cur;
      next_cur.prdata = rd ? rdata : cur.prdata;
      // register writes, reserved bits masked away
      if (wr && mapped)
      begin
         if (is_sub)
            next_cur.upper_addr_replace[sub_idx] =
               PWDATA[`SUB_MSB:`SUB_LSB];
         else
            case (PADDR)
               `OFS_MASTER_CFG: next_cur.master_configuration =
                  PWDATA & `MASTER_CFG_MASK;
               `OFS_IDENTITY_PROG: next_cur.identity_program = PWDATA;
               `OFS_CLASS_REV_PROG: next_cur.class_revision_program = PWDATA;
               `OFS_SUBSYS_PROG: next_cur.subsystem_identity_program = PWDATA;
               `OFS_LAT_GNT_PROG: next_cur.latency_grant_program =
                  PWDATA[15:0];
               `OFS_CFG_COMPLETE: next_cur.configuration_complete = PWDATA[0];
               default: ;
            endcase
      end
      // pci reset latches the hook values into the live header;
      // it is a level, so while it stays high the mirrors follow the
      // program registers and a write in that window reaches them too
      if (PCI_RST)
      begin
         next_cur.identity_mirror = cur.identity_program;
         next_cur.class_revision_mirror = cur.class_revision_program;
         next_cur.subsystem_mirror = cur.subsystem_identity_program;
         next_cur.latency_grant_mirror = cur.latency_grant_program;
      end
      // proxy jobs: done clears, new request sets and wins over done;
      // a flush beats a new request, else a job would sit pending with
      // the master off and nothing left to serve it
      if (PROXY_DONE)
      begin
         next_cur.hold.cfg_pending = 1'b0;
         next_cur.hold.io_pending = 1'b0;
      end
      if (!BUS_MASTER_ENABLE && cur.master_configuration[`BIT_CFG_FLUSH])
         next_cur.hold.cfg_pending = 1'b0;
      else if (CFG_PROXY_REQ)
         next_cur.hold.cfg_pending = 1'b1;
      if (!BUS_MASTER_ENABLE && cur.master_configuration[`BIT_IO_FLUSH])
         next_cur.hold.io_pending = 1'b0;
      else if (IO_PROXY_REQ)
         next_cur.hold.io_pending = 1'b1;
      // memory request gate; while flushing it still shows ready, so the
      // request is consumed and dropped instead of stalling the master
      next_cur.hold.mem_held = 1'b0;
      case (cur.mstate)
         ST_IDLE:
         begin
            if (MEM_REQ.valid && !(!BUS_MASTER_ENABLE && mem_flush_en))
            begin
               next_cur.hold.mem = MEM_REQ;
               next_cur.mstate = ST_HOLD;
            end // else dropped when flushing
         end
         ST_HOLD:
         begin
            if (BUS_MASTER_ENABLE)
            begin
               next_cur.issue.valid = 1'b1;
               next_cur.issue.cmd = mem_cmd;
               next_cur.issue.addr = xlat_addr;
               next_cur.mstate = ST_ISSUE;
            end
            else if (mem_flush_en)
               next_cur.mstate = ST_IDLE;
            else
               next_cur.hold.mem_held = 1'b1;
         end
         ST_ISSUE:
         begin
            // the agent's ready ends the issue; the gate frees on that same edge
            if (BUS_ISSUE_READY)
            begin
               next_cur.issue.valid = 1'b0;
               next_cur.mstate = ST_IDLE;
            end
         end
         default: next_cur.mstate = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // synchronous reset; the struct clear covers every field, the named
   // values restate the config and hook program registers; mstate gets ST_IDLE
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cur <= '0;
         cur.master_configuration <= `RST_MASTER_CFG;
         cur.identity_program <= `RST_IDENTITY;
         cur.class_revision_program <= `RST_CLASS_REV;
         cur.subsystem_identity_program <= `RST_SUBSYS;
         cur.latency_grant_program <= 16'(`RST_LAT_GNT);
         cur.configuration_complete <= 1'(`RST_CFG_COMPLETE);
         cur.mstate <= ST_IDLE;
      end
      else
         cur <= next_cur;
   end
endmodule

// ===== testbench/pci_agent_model.sv
// far side bus agent: accepts issued commands, prompt or slow
// assumes the issue stands until the edge where ready is high
`timescale 1ns/100ps
module pci_agent_model
   import pci_master_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire bus_issue_t issue,
   output logic ready,
   output logic [31:0] taken,
   output bus_issue_t last
);
   logic [1:0] wait_cnt;
   // ----------------------------------------
   // acceptance, one ready edge per command
   // ----------------------------------------
   // slow mode stalls three cycles to test the hold
   always_ff @(posedge clk)
   begin
      if (rst || !issue.valid || ready)
      begin
         ready <= 1'b0;
         wait_cnt <= slow ? 2'h3 : 2'h0;
      end
      else if (wait_cnt != 2'h0)
         wait_cnt <= wait_cnt - 2'h1;
      else
         ready <= 1'b1;
      if (rst)
         taken <= 32'h0;
      else if (issue.valid && ready)
      begin
         taken <= taken + 32'h1;
         last <= issue;
      end
   end
endmodule

// ===== testbench/pci_master_cfg_properties.sv
// assertions on the ports of the master config register bank
// assumes one clock, sync reset, bound into pci_master_cfg below
`timescale 1ns/100ps
module pci_master_cfg_properties
   import pci_master_cfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PCI_RST,
   input wire logic BUS_MASTER_ENABLE,
   input wire logic CFG_PROXY_REQ,
   input wire logic CFG_PROXY_PENDING,
   input wire logic IO_PROXY_PENDING,
   input wire mem_req_t MEM_REQ,
   input wire logic MEM_REQ_READY,
   input wire bus_issue_t BUS_ISSUE,
   input wire logic [31:0] IDENTITY_MIRROR,
   input wire logic HOST_ACCESS_ALLOWED
);
   logic [10:0] cfg;
   logic off;
   logic wrq;
   // ----------------------------------------
   // shadow of master config, from bus writes
   // ----------------------------------------
   assign off = !BUS_MASTER_ENABLE;
   assign wrq = PSEL && PENABLE && PWRITE;
   // same edge as the design's own register
   always_ff @(posedge CLK)
      if (RST)
         cfg <= 11'h0;
      else if (wrq && PADDR == 12'h300)
         cfg <= PWDATA[10:0];
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   mirror_hold_a: assert property (
      !PCI_RST |=> $stable(IDENTITY_MIRROR)) else $error("mirror moved");
   host_gate_a: assert property (
      wrq && PADDR == 12'h3ac |=> {31'h0, HOST_ACCESS_ALLOWED} ==
      ($past(PWDATA) & 32'h1)) else $error("host gate wrong");
   cmd_gate_a: assert property (
      BUS_ISSUE.valid |-> (BUS_ISSUE.cmd != CMD_MEM_READ_MULT || cfg[2])
      && (BUS_ISSUE.cmd != CMD_MEM_READ_LINE || cfg[1])
      && (BUS_ISSUE.cmd != CMD_MEM_WRITE_INV || cfg[0]))
      else $error("disabled command issued");
   master_off_a: assert property (
      off [*2] |-> !$rose(BUS_ISSUE.valid)) else $error("issue while off");
   mem_flush_a: assert property (
      MEM_REQ.valid && MEM_REQ_READY && off && cfg[8] |=> MEM_REQ_READY)
      else $error("flushed request kept");
   cfg_flush_a: assert property (
      off && cfg[10] |=> !CFG_PROXY_PENDING) else $error("cfg not flushed");
   io_flush_a: assert property (
      off && cfg[9] |=> !IO_PROXY_PENDING) else $error("io not flushed");
   proxy_keep_a: assert property (
      CFG_PROXY_REQ && !(off && cfg[10]) |=> CFG_PROXY_PENDING)
      else $error("cfg job lost");
endmodule
bind pci_master_cfg pci_master_cfg_properties props
(
   .CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PCI_RST,
   .BUS_MASTER_ENABLE, .CFG_PROXY_REQ, .CFG_PROXY_PENDING,
   .IO_PROXY_PENDING, .MEM_REQ, .MEM_REQ_READY, .BUS_ISSUE,
   .IDENTITY_MIRROR, .HOST_ACCESS_ALLOWED
);

// ===== testbench/tb_pci_master_cfg.sv
// self-checking bench for the master config register bank
// assumes the agent model on the bus issue side
`timescale 1ns/100ps
module tb_pci_master_cfg
   import pci_master_cfg_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic pci_rst = 1'b0, bme = 1'b0, creq = 1'b0, ireq = 1'b0;
   logic done = 1'b0, slow = 1'b0, se, serr, prdy, mrdy, irdy;
   logic cpend, ipend, host;
   logic [11:0] padr = 12'h0;
   logic [31:0] pwd = 32'h0, prd, rdv, idm, crm, ssm, taken, t0;
   logic [31:0] sub [32];
   logic [15:0] lgm;
   mem_req_t mreq = '0;
   bus_issue_t iss, last;
   logic [11:0] ofs [7] = '{12'h300, 12'h200, 12'h394, 12'h39c,
      12'h3a0, 12'h3a4, 12'h3ac};
   logic [31:0] msk [7] = '{32'h707, 32'hff800000, 32'hffffffff,
      32'hffffffff, 32'hffffffff, 32'hffff, 32'h1};
   int error_cnt = 0, checks = 0, cyc = 0;
   pci_master_cfg uut
   (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
      .PSLVERR(serr), .PCI_RST(pci_rst), .BUS_MASTER_ENABLE(bme),
      .CFG_PROXY_REQ(creq), .IO_PROXY_REQ(ireq), .PROXY_DONE(done),
      .CFG_PROXY_PENDING(cpend), .IO_PROXY_PENDING(ipend),
      .MEM_REQ(mreq), .MEM_REQ_READY(mrdy), .BUS_ISSUE(iss),
      .BUS_ISSUE_READY(irdy), .IDENTITY_MIRROR(idm),
      .CLASS_REVISION_MIRROR(crm), .SUBSYSTEM_MIRROR(ssm),
      .LATENCY_GRANT_MIRROR(lgm), .HOST_ACCESS_ALLOWED(host)
   );
   pci_agent_model agent
   (
      .clk(clk), .rst(rst), .slow(slow), .issue(iss), .ready(irdy),
      .taken(taken), .last(last)
   );
   // ----------------------------------------
   // clock, hang guard and shared tasks
   // ----------------------------------------
   always #10 clk = ~clk;
   // the run needs a few thousand cycles at most
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         $display("MISMATCH %0t timeout", $time);
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string what);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s %h/%h", $time, what, got, exp);
      end
   endtask
   // idle edge first, so a release never meets a new setup
   task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      se = serr;
      rdv = prd;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // one read; the data stands in the access phase itself
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic send(input logic w, logic [31:0] a, logic [7:0] n);
      t0 = taken;
      @(posedge clk);
      mreq <= '{1'b1, w, a, n};
      do @(posedge clk); while (mrdy !== 1'b1);
      mreq.valid <= 1'b0;
   endtask
   task automatic took(input logic exp, input string what);
      logic got;
      got = 1'b0;
      repeat (20) @(posedge clk) if (taken !== t0) got = 1'b1;
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask
   function automatic logic [3:0] ecmd(logic [2:0] c, logic w, int n);
      if (w)
         return (n >= 8 && c[0]) ? CMD_MEM_WRITE_INV : CMD_MEM_WRITE;
      if (n >= 8 && c[2])
         return CMD_MEM_READ_MULT;
      return (n >= 8 && c[1]) ? CMD_MEM_READ_LINE : CMD_MEM_READ;
   endfunction
   // main sequence
   initial
   begin
      logic [31:0] a, e;
      void'($urandom(32'he643));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk({31'h0, host}, 32'h0, "host refused");
      for (int i = 0; i < 7; i++)
      begin
         rd(ofs[i]);
         chk(rdv, 32'h0, "reset value");
         e = $urandom();
         apb(1'b1, ofs[i], e);
         rd(ofs[i]);
         chk(rdv, e & msk[i], "read back");
      end
      apb(1'b1, 12'h3a8, 32'hffffffff);
      chk({31'h0, se}, 32'h1, "unmapped err");
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         sub[i] = $urandom();
         apb(1'b1, ofs[i + 2], sub[i]);
      end
      chk(idm, 32'h0, "mirror early");
      @(posedge clk) pci_rst <= 1'b1;
      @(posedge clk) pci_rst <= 1'b0;
      @(posedge clk);
      chk(idm, sub[0], "id mirror");
      chk(crm, sub[1], "class mirror");
      chk(ssm, sub[2], "subsys mirror");
      chk({16'h0, lgm}, sub[3] & 32'hffff, "lat mirror");
      apb(1'b1, 12'h3ac, 32'h1);
      @(posedge clk);
      chk({31'h0, host}, 32'h1, "host allowed");
      $display("test hooks done");
      for (int i = 0; i < 32; i++)
      begin
         sub[i] = $urandom();
         apb(1'b1, 12'h200 + 12'(4 * i), sub[i]);
      end
      bme <= 1'b1;
      for (int j = 0; j < 32; j++)
      begin
         slow <= j[0] ^ 1'($urandom());
         apb(1'b1, 12'h300, {29'h0, j[2:0]});
         a = $urandom();
         send(j[3], a, j[4] ? 8'h08 : 8'h07);
         took(1'b1, "issued");
         chk({28'h0, last.cmd}, {28'h0, ecmd(j[2:0], j[3], j[4] + 7)},
            "command");
         chk(last.addr, {sub[a[27:23]][31:23], a[22:0]}, "addr");
      end
      $display("test commands done");
      bme <= 1'b0;
      apb(1'b1, 12'h300, 32'h0);
      send(1'b0, 32'h0, 8'h01);
      took(1'b0, "held");
      rd(12'h304);
      chk(rdv, 32'h10, "held status");
      bme <= 1'b1;
      took(1'b1, "released");
      bme <= 1'b0;
      apb(1'b1, 12'h300, 32'h100);
      send(1'b1, 32'h0, 8'h08);
      bme <= 1'b1;
      took(1'b0, "mem flushed");
      bme <= 1'b0;
      apb(1'b1, 12'h300, 32'h0);
      send(1'b0, 32'h0, 8'h01);
      apb(1'b1, 12'h300, 32'h100);
      @(posedge clk);
      bme <= 1'b1;
      took(1'b0, "hold flushed");
      bme <= 1'b0;
      apb(1'b1, 12'h300, 32'h0);
      creq <= 1'b1;
      ireq <= 1'b1;
      @(posedge clk);
      creq <= 1'b0;
      ireq <= 1'b0;
      @(posedge clk);
      chk({30'h0, cpend, ipend}, 32'h3, "jobs kept");
      rd(12'h304);
      chk(rdv, 32'h0c, "job status");
      apb(1'b1, 12'h300, 32'h600);
      repeat (2) @(posedge clk);
      chk({30'h0, cpend, ipend}, 32'h0, "jobs flushed");
      apb(1'b1, 12'h300, 32'h0);
      creq <= 1'b1;
      @(posedge clk);
      creq <= 1'b0;
      done <= 1'b1;
      @(posedge clk);
      chk({31'h0, cpend}, 32'h1, "job set");
      done <= 1'b0;
      @(posedge clk);
      chk({31'h0, cpend}, 32'h0, "job done");
      $display("test flush done");
      final_report();
   end
endmodule
